// >>> hw/seq_pkg.sv
// constants, state codes and register map of the buck start-up and protection sequencer
// assumes a 125 MHz system clock and a plain register port with byte offsets
//
// Notes on behaviour
// - a valid high on the enable pin starts the start-up sequence from off.
// - soft-start ramp lasts 512 switching clock cycles, scaling with switching rate.
// - bootstrap pre-charge runs only after an enable rising edge, before soft-start.
// - pre-charge toggles lower gate at 1.5 MHz, 50% duty, for 64 cycles.
// - undervoltage ignored until quarter of the ramp is done; earlier clearing is harmless.
// - undervoltage from the quarter point to ramp end aborts, waits 512 cycles, restarts soft-start.
// - with a pre-charged output both gate drives stay undriven, high impedance.
// - output above overvoltage threshold in soft-start or run turns the lower switch on until nominal.
// - continuous conduction only; both switches never idle within a normal period.
// - off time below minimum gives high-duty skipping, whole off interval omitted.
// - on time below minimum gives low-duty skipping, whole on pulse omitted.
// - upper gate only with enough boot charge; otherwise lower switch recharges it.
// - overcurrent while upper switch conducts ends the on pulse at once.
// - switching clock from resistor rate 100-700 kHz or external 350-700 kHz.
// - upper gate minimum on and off times of 100 ns bound pulse skipping.

package seq_pkg;

	// ----------------------------------------
	// clock and timing
	// ----------------------------------------
	localparam int CLK_KHZ     = 125000;
	localparam int MIN_ON_NS   = 100;
	localparam int MIN_OFF_NS  = 100;
	localparam int DEAD_NS     = 24;
	localparam int PC_KHZ      = 1500;
	localparam int SYNC_MIN_KHZ = 350;
	localparam int SYNC_MAX_KHZ = 700;
	localparam int RES_MIN_KHZ = 100;
	localparam int RES_DEF_KHZ = 500;

	localparam int PER_W = 11;
	localparam logic [PER_W-1:0] MIN_ON_CYC  = PER_W'((MIN_ON_NS * CLK_KHZ + 999999) / 1000000);
	localparam logic [PER_W-1:0] MIN_OFF_CYC = PER_W'((MIN_OFF_NS * CLK_KHZ + 999999) / 1000000);
	localparam logic [2:0]       DEAD_CYC    = 3'((DEAD_NS * CLK_KHZ + 999999) / 1000000);
	localparam logic [PER_W-1:0] PER_MIN     = PER_W'(CLK_KHZ / SYNC_MAX_KHZ);
	localparam logic [PER_W-1:0] PER_MAX_EXT = PER_W'(CLK_KHZ / SYNC_MIN_KHZ);
	localparam logic [PER_W-1:0] PER_MAX_RES = PER_W'(CLK_KHZ / RES_MIN_KHZ);
	localparam logic [PER_W-1:0] PER_RESET   = PER_W'(CLK_KHZ / RES_DEF_KHZ);

	localparam logic [6:0] PC_PERIOD = 7'(CLK_KHZ / PC_KHZ);
	localparam logic [6:0] PC_HALF   = 7'(CLK_KHZ / PC_KHZ / 2);
	localparam logic [6:0] PC_PULSES = 7'h40;

	localparam int SS_W = 10;
	localparam logic [SS_W-1:0] SS_LAST    = 10'h1FF;
	localparam logic [SS_W-1:0] SS_QUARTER = 10'h080;
	localparam logic [SS_W-1:0] RETRY_LAST = 10'h1FF;
	localparam int SS_SHIFT = 9;

	// ----------------------------------------
	// synchronised inputs
	// ----------------------------------------
	localparam int IN_W    = 8;
	localparam int IN_EN   = 0;
	localparam int IN_SRC  = 1;
	localparam int IN_MODE = 2;
	localparam int IN_UV   = 3;
	localparam int IN_OV   = 4;
	localparam int IN_BOOT = 5;
	localparam int IN_OC   = 6;
	localparam int IN_PRE  = 7;

	// ----------------------------------------
	// sequencer states
	// ----------------------------------------
	typedef enum logic [2:0] {
		ST_OFF       = 3'b000,
		ST_PRECHARGE = 3'b001,
		ST_SOFTSTART = 3'b010,
		ST_RUN       = 3'b011,
		ST_RETRY     = 3'b100,
		ST_HIZ       = 3'b101
	} state_e;

	// ----------------------------------------
	// registers and events
	// ----------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] REG_DUTY   = 8'h00;
	localparam logic [ADDR_W-1:0] REG_PERIOD = 8'h04;
	localparam logic [ADDR_W-1:0] REG_STATUS = 8'h08;
	localparam logic [ADDR_W-1:0] REG_IRQ    = 8'h0C;
	localparam logic [ADDR_W-1:0] REG_MASK   = 8'h10;
	localparam logic [PER_W-1:0]  DUTY_RESET = 11'h000;

	localparam int EV_W       = 6;
	localparam int EV_UV      = 0;
	localparam int EV_OC      = 1;
	localparam int EV_OV      = 2;
	localparam int EV_BOOT    = 3;
	localparam int EV_SS_DONE = 4;
	localparam int EV_FREQ    = 5;

endpackage

// >>> hw/sync_bank.sv
// two-flop synchroniser bank for asynchronous input pins
// assumes one clock; the first stage is read only by the second

`timescale 1ns/10ps
`default_nettype none

module sync_bank #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta <= '0;
			q    <= '0;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end

endmodule // sync_bank

`default_nettype wire

// >>> hw/buck_softstart_protection_seq.sv
// start-up, soft-start and protection sequencer driving external high and low side switches
// assumes comparator levels arrive asynchronously and a plain register port on clk

`timescale 1ns/10ps
`default_nettype none

module buck_softstart_protection_seq (
	input  wire logic                       clk,
	input  wire logic                       rst_n,
	input  wire logic                       enable_pin,
	input  wire logic                       clock_source_pin,
	input  wire logic                       resistor_set_rate_mode,
	input  wire logic                       undervoltage_fault,
	input  wire logic                       output_monitor_pin,
	input  wire logic                       boot_cap_pin,
	input  wire logic                       overcurrent_trip,
	input  wire logic                       output_precharged,
	input  wire logic [seq_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic [31:0]                reg_wdata,
	input  wire logic                       reg_wr,
	input  wire logic                       reg_rd,
	output logic      [31:0]                reg_rdata,
	output logic                            upper_gate,
	output logic                            upper_gate_oe,
	output logic                            lower_gate,
	output logic                            lower_gate_oe,
	output logic                            irq
);
	import seq_pkg::*;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [PER_W-1:0] clamp_per(input logic [PER_W-1:0] v,
		input logic [PER_W-1:0] lo, input logic [PER_W-1:0] hi);
		if (v < lo)
			return lo;
		else if (v > hi)
			return hi;
		else
			return v;
	endfunction

	function automatic logic [PER_W-1:0] min_per(input logic [PER_W-1:0] a,
		input logic [PER_W-1:0] b);
		return (a < b) ? a : b;
	endfunction

	// ----------------------------------------
	// input synchronisation
	// ----------------------------------------
	logic [IN_W-1:0] pin_raw;
	logic [IN_W-1:0] pin;

	assign pin_raw = {output_precharged, overcurrent_trip, boot_cap_pin, output_monitor_pin,
		undervoltage_fault, resistor_set_rate_mode, clock_source_pin, enable_pin};

	sync_bank #(.W(IN_W)) u_sync (
		.clk   (clk),
		.rst_n (rst_n),
		.d     (pin_raw),
		.q     (pin)
	);

	logic en_s;
	logic src_s;
	logic mode_res;
	logic uv_s;
	logic ov_s;
	logic boot_ok;
	logic oc_s;
	logic pre_s;

	assign en_s     = pin[IN_EN];
	assign src_s    = pin[IN_SRC];
	assign mode_res = pin[IN_MODE];
	assign uv_s     = pin[IN_UV];
	assign ov_s     = pin[IN_OV];
	assign boot_ok  = pin[IN_BOOT];
	assign oc_s     = pin[IN_OC];
	assign pre_s    = pin[IN_PRE];

	logic en_q;
	logic src_q;
	logic ov_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			en_q  <= 1'b0;
			src_q <= 1'b0;
			ov_q  <= 1'b0;
		end else begin
			en_q  <= en_s;
			src_q <= src_s;
			ov_q  <= ov_s;
		end
	end

	// ----------------------------------------
	// registers written by software
	// ----------------------------------------
	logic [PER_W-1:0] duty_reg;
	logic [PER_W-1:0] period_reg;
	logic [EV_W-1:0]  irq_mask;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			duty_reg   <= DUTY_RESET;
			period_reg <= PER_RESET;
			irq_mask   <= '0;
		end else if (reg_wr) begin
			if (reg_addr == REG_DUTY)
				duty_reg <= reg_wdata[PER_W-1:0];
			if (reg_addr == REG_PERIOD)
				period_reg <= reg_wdata[PER_W-1:0];
			if (reg_addr == REG_MASK)
				irq_mask <= reg_wdata[EV_W-1:0];
		end
	end

	// ----------------------------------------
	// switching clock source
	// ----------------------------------------
	logic [PER_W-1:0] res_period;
	logic [PER_W-1:0] div_cnt;
	logic [PER_W-1:0] ext_cnt;
	logic [PER_W-1:0] period_len;
	logic             sw_tick;
	logic             freq_err;

	assign res_period = clamp_per(period_reg, PER_MIN, PER_MAX_RES);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div_cnt    <= '0;
			ext_cnt    <= '0;
			period_len <= PER_RESET;
			sw_tick    <= 1'b0;
			freq_err   <= 1'b0;
		end else begin
			sw_tick  <= 1'b0;
			freq_err <= 1'b0;
			if (mode_res) begin
				ext_cnt <= '0;
				if (div_cnt >= res_period - 11'h001) begin
					div_cnt    <= '0;
					sw_tick    <= 1'b1;
					period_len <= res_period;
				end else begin
					div_cnt <= div_cnt + 11'h001;
				end
			end else begin
				div_cnt <= '0;
				if (src_s && !src_q) begin
					ext_cnt <= 11'h001;
					if (ext_cnt >= PER_MIN && ext_cnt <= PER_MAX_EXT) begin
						sw_tick    <= 1'b1;
						period_len <= ext_cnt;
					end else if (ext_cnt != '0) begin
						freq_err <= 1'b1;
					end
				end else if (ext_cnt != '1 && ext_cnt != '0) begin
					ext_cnt <= ext_cnt + 11'h001;
				end
			end
		end
	end

	// ----------------------------------------
	// start-up sequencer
	// ----------------------------------------
	state_e          state;
	logic [6:0]      pc_cnt;
	logic [6:0]      pc_pulses;
	logic [SS_W-1:0] ss_cnt;
	logic [SS_W-1:0] retry_cnt;
	logic            ev_uv;
	logic            ev_ss_done;
	logic            quarter_ramp_done;
	logic            active;

	assign quarter_ramp_done = (state == ST_SOFTSTART) && (ss_cnt >= SS_QUARTER);
	assign active = (state == ST_SOFTSTART) || (state == ST_RUN);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state      <= ST_OFF;
			pc_cnt     <= '0;
			pc_pulses  <= '0;
			ss_cnt     <= '0;
			retry_cnt  <= '0;
			ev_uv      <= 1'b0;
			ev_ss_done <= 1'b0;
		end else begin
			ev_uv      <= 1'b0;
			ev_ss_done <= 1'b0;
			if (!en_s) begin
				state     <= ST_OFF;
				pc_cnt    <= '0;
				pc_pulses <= '0;
				ss_cnt    <= '0;
				retry_cnt <= '0;
			end else begin
				unique case (state)
					ST_OFF: begin
						if (!en_q) begin
							pc_cnt    <= '0;
							pc_pulses <= '0;
							state     <= pre_s ? ST_HIZ : ST_PRECHARGE;
						end
					end
					ST_HIZ: begin
						if (!pre_s) begin
							ss_cnt <= '0;
							state  <= ST_SOFTSTART;
						end
					end
					ST_PRECHARGE: begin
						if (pc_cnt == PC_PERIOD - 7'h01) begin
							pc_cnt <= '0;
							if (pc_pulses == PC_PULSES - 7'h01) begin
								ss_cnt <= '0;
								state  <= ST_SOFTSTART;
							end else begin
								pc_pulses <= pc_pulses + 7'h01;
							end
						end else begin
							pc_cnt <= pc_cnt + 7'h01;
						end
					end
					ST_SOFTSTART: begin
						if (quarter_ramp_done && uv_s) begin
							retry_cnt <= '0;
							ev_uv     <= 1'b1;
							state     <= ST_RETRY;
						end else if (sw_tick) begin
							if (ss_cnt == SS_LAST) begin
								ev_ss_done <= 1'b1;
								state      <= ST_RUN;
							end else begin
								ss_cnt <= ss_cnt + 10'h001;
							end
						end
					end
					ST_RETRY: begin
						if (sw_tick) begin
							if (retry_cnt == RETRY_LAST) begin
								ss_cnt <= '0;
								state  <= ST_SOFTSTART;
							end else begin
								retry_cnt <= retry_cnt + 10'h001;
							end
						end
					end
					ST_RUN: begin
						state <= ST_RUN;
					end
					default: begin
						state <= ST_OFF;
					end
				endcase
			end
		end
	end

	// ----------------------------------------
	// pulse width and skipping
	// ----------------------------------------
	logic [PER_W-1:0]      ph;
	logic [PER_W-1:0]      on_cyc;
	logic [PER_W-1:0]      on_req;
	logic [PER_W+SS_W-1:0] ramp_prod;
	logic [PER_W-1:0]      ramp_lim;
	logic                  lo_skip;
	logic                  hi_skip;
	logic                  oc_cut;
	logic                  ev_oc;
	logic                  pwm_hs;

	assign ramp_prod = period_len * (ss_cnt + 10'h001);
	assign ramp_lim  = (state == ST_RUN) ? period_len : PER_W'(ramp_prod >> SS_SHIFT);
	assign on_req    = min_per(duty_reg, ramp_lim);
	assign pwm_hs    = active && (ph < on_cyc) && !oc_cut;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ph      <= '0;
			on_cyc  <= '0;
			lo_skip <= 1'b0;
			hi_skip <= 1'b0;
			oc_cut  <= 1'b0;
			ev_oc   <= 1'b0;
		end else begin
			ev_oc <= 1'b0;
			if (sw_tick) begin
				ph     <= '0;
				oc_cut <= 1'b0;
				if (on_req < MIN_ON_CYC) begin
					on_cyc  <= '0;
					lo_skip <= 1'b1;
					hi_skip <= 1'b0;
				end else if (period_len - on_req < MIN_OFF_CYC) begin
					on_cyc  <= '1;
					lo_skip <= 1'b0;
					hi_skip <= 1'b1;
				end else begin
					on_cyc  <= on_req;
					lo_skip <= 1'b0;
					hi_skip <= 1'b0;
				end
			end else if (ph != '1) begin
				ph <= ph + 11'h001;
			end
			if (upper_gate && oc_s && !oc_cut) begin
				oc_cut <= 1'b1;
				ev_oc  <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// gate drive with non-overlap
	// ----------------------------------------
	logic       want_hs;
	logic       want_ls;
	logic [2:0] dead;

	assign want_hs = pwm_hs && boot_ok && !ov_s;
	assign want_ls = (state == ST_PRECHARGE) ? (pc_cnt < PC_HALF) :
		(active && !want_hs);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			upper_gate    <= 1'b0;
			lower_gate    <= 1'b0;
			upper_gate_oe <= 1'b1;
			lower_gate_oe <= 1'b1;
			dead          <= '0;
		end else begin
			upper_gate_oe <= (state != ST_HIZ);
			lower_gate_oe <= (state != ST_HIZ);
			if (upper_gate && !want_hs) begin
				upper_gate <= 1'b0;
				dead       <= DEAD_CYC;
			end else if (lower_gate && !want_ls) begin
				lower_gate <= 1'b0;
				dead       <= DEAD_CYC;
			end else if (dead != '0) begin
				dead <= dead - 3'h1;
			end else if (want_hs && !lower_gate) begin
				upper_gate <= 1'b1;
			end else if (want_ls && !upper_gate) begin
				lower_gate <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// interrupt status
	// ----------------------------------------
	logic [EV_W-1:0] events;
	logic [EV_W-1:0] irq_stat;
	logic [EV_W-1:0] irq_clr;

	always_comb begin
		events             = '0;
		events[EV_UV]      = ev_uv;
		events[EV_OC]      = ev_oc;
		events[EV_OV]      = active && ov_s && !ov_q;
		events[EV_BOOT]    = sw_tick && active && !boot_ok;
		events[EV_SS_DONE] = ev_ss_done;
		events[EV_FREQ]    = freq_err;
	end

	assign irq_clr = (reg_wr && reg_addr == REG_IRQ) ? reg_wdata[EV_W-1:0] : '0;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_stat <= '0;
			irq      <= 1'b0;
		end else begin
			irq_stat <= (irq_stat & ~irq_clr) | events;
			irq      <= |(((irq_stat & ~irq_clr) | events) & irq_mask);
		end
	end

	// ----------------------------------------
	// register read
	// ----------------------------------------
	logic [31:0] status_word;

	assign status_word = 32'({period_len, ss_cnt, mode_res, boot_ok, oc_cut, hi_skip, lo_skip,
		quarter_ramp_done, state});

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			unique case (reg_addr)
				REG_DUTY:   reg_rdata <= 32'(duty_reg);
				REG_PERIOD: reg_rdata <= 32'(period_reg);
				REG_STATUS: reg_rdata <= status_word;
				REG_IRQ:    reg_rdata <= 32'(irq_stat);
				REG_MASK:   reg_rdata <= 32'(irq_mask);
				default:    reg_rdata <= '0;
			endcase
		end else begin
			reg_rdata <= '0;
		end
	end

endmodule // buck_softstart_protection_seq

`default_nettype wire

// >>> testbench/seq_checker.sv
// port assertions for the start-up and protection sequencer
// assumes binding into the top module, one clock domain
`timescale 1ns/10ps
`default_nettype none
module seq_checker (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic enable_pin,
	input wire logic output_monitor_pin,
	input wire logic boot_cap_pin,
	input wire logic overcurrent_trip,
	input wire logic output_precharged,
	input wire logic upper_gate,
	input wire logic upper_gate_oe,
	input wire logic lower_gate,
	input wire logic lower_gate_oe
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	// ----
	// gate drive
	// ----
	no_overlap_a: assert property (!(upper_gate && lower_gate))
		else $error("gates overlap");
	lower_gap_a: assert property ($fell(lower_gate) |-> !upper_gate [*2])
		else $error("no gap after lower fall");
	upper_gap_a: assert property ($fell(upper_gate) |-> !lower_gate [*2])
		else $error("no gap after upper fall");
	oe_pair_a: assert property (upper_gate_oe == lower_gate_oe)
		else $error("enables differ");
	hiz_quiet_a: assert property (!lower_gate_oe |-> !lower_gate && !upper_gate)
		else $error("gate high while released");
	off_release_a: assert property (!enable_pin [*8] |-> !upper_gate && !lower_gate && lower_gate_oe)
		else $error("gates active while off");
	// ----
	// start-up and protection
	// ----
	start_charge_a: assert property ($rose(enable_pin) && !output_precharged |-> ##[2:8] lower_gate)
		else $error("no pre-charge pulse");
	charge_upper_a: assert property ($rose(enable_pin) |-> !upper_gate [*8])
		else $error("upper on during pre-charge");
	boot_gate_a: assert property ($rose(upper_gate) |-> $past(boot_cap_pin, 2) || $past(boot_cap_pin, 3) || $past(boot_cap_pin, 4))
		else $error("upper on with low boot charge");
	oc_cut_a: assert property ($rose(overcurrent_trip) && upper_gate |-> ##[1:6] !upper_gate)
		else $error("pulse not cut");
	ov_upper_a: assert property (output_monitor_pin [*6] |-> !upper_gate)
		else $error("upper on during overvoltage");
	cover property ($rose(upper_gate));
	cover property ($fell(lower_gate_oe));
	cover property (overcurrent_trip && upper_gate);
endmodule // seq_checker
bind buck_softstart_protection_seq seq_checker chk (.clk(clk), .rst_n(rst_n),
	.enable_pin(enable_pin), .output_monitor_pin(output_monitor_pin),
	.boot_cap_pin(boot_cap_pin), .overcurrent_trip(overcurrent_trip),
	.output_precharged(output_precharged), .upper_gate(upper_gate),
	.upper_gate_oe(upper_gate_oe), .lower_gate(lower_gate), .lower_gate_oe(lower_gate_oe));
`default_nettype wire

// >>> testbench/fet_pair_model.sv
// external high and low side switches with a bootstrap capacitor
// assumes gate levels from the sequencer; leak drains the capacitor on command
`timescale 1ns/10ps
`default_nettype none
module fet_pair_model (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic upper_gate,
	input  wire logic upper_gate_oe,
	input  wire logic lower_gate,
	input  wire logic lower_gate_oe,
	input  wire logic leak,
	output logic      boot_ok,
	output logic      shoot
);
	logic [7:0] charge;
	// ----
	// boot charge and shoot-through
	// ----
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			charge <= 8'h00;
			shoot <= 1'b0;
		end else begin
			if (leak && charge != 8'h00)
				charge <= charge - 8'h01;
			else if (lower_gate && lower_gate_oe && charge != 8'hFF)
				charge <= charge + 8'h01;
			else if (upper_gate && upper_gate_oe && charge != 8'h00)
				charge <= charge - 8'h01;
			if (upper_gate && lower_gate)
				shoot <= 1'b1;
		end
	end
	assign boot_ok = charge > 8'h40;
endmodule // fet_pair_model
`default_nettype wire

// >>> testbench/buck_softstart_protection_seq_bench.sv
// self-checking bench for the start-up and protection sequencer
// assumes the design package, the bound checker and the switch model
`timescale 1ns/10ps
`default_nettype none
module buck_softstart_protection_seq_bench;
	import seq_pkg::*;
	logic              clk = 1'b0, rst_n = 1'b0, en = 1'b0, src = 1'b0, rmode = 1'b1;
	logic              uv = 1'b0, ov = 1'b0, oc = 1'b0, pre = 1'b0, leak = 1'b0;
	logic              wr = 1'b0, rd = 1'b0, lg_q = 1'b0;
	logic              ug, ugoe, lg, lgoe, irq, boot, shoot;
	logic [ADDR_W-1:0] addr = 8'h00;
	logic [31:0]       wdata = 32'h0, lfsr = 32'hC6FD, v, rdata, duty;
	int                mismatches = 0, n_checks = 0, cycles = 0;
	int                ext_half = 124, ext_cnt = 0, lg_w = 0, pc_pulses = 0;
	logic [7:0]        ra [4] = '{8'h00, 8'h04, 8'h10, 8'h14};
	logic [31:0]       rv [4] = '{32'h0, 32'hFA, 32'h0, 32'h0};
	buck_softstart_protection_seq DUT (.clk(clk), .rst_n(rst_n), .enable_pin(en),
		.clock_source_pin(src), .resistor_set_rate_mode(rmode), .undervoltage_fault(uv),
		.output_monitor_pin(ov), .boot_cap_pin(boot), .overcurrent_trip(oc),
		.output_precharged(pre), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr),
		.reg_rd(rd), .reg_rdata(rdata), .upper_gate(ug), .upper_gate_oe(ugoe),
		.lower_gate(lg), .lower_gate_oe(lgoe), .irq(irq));
	fet_pair_model fets (.clk(clk), .rst_n(rst_n), .upper_gate(ug), .upper_gate_oe(ugoe),
		.lower_gate(lg), .lower_gate_oe(lgoe), .leak(leak), .boot_ok(boot), .shoot(shoot));
	// ----
	// clock, external rate source, pulse counter, timeout
	// ----
	always #4 clk = ~clk;
	always @(posedge clk) begin
		cycles <= cycles + 1;
		ext_cnt <= (ext_cnt >= ext_half) ? 0 : ext_cnt + 1;
		if (ext_cnt >= ext_half)
			src <= ~src;
		lg_q <= lg;
		lg_w <= lg ? lg_w + 1 : 0;
		if (!lg && lg_q && lg_w < 50)
			pc_pulses <= pc_pulses + 1;
		if (cycles == 60000) begin
			mismatches = mismatches + 1;
			give_verdict;
		end
	end
	// ----
	// tasks and functions
	// ----
	function automatic logic [31:0] next_rand(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic low_skip(input logic [9:0] c);
		return ((32'hB2 * ({22'h0, c} + 32'h1)) >> 9) < 32'(MIN_ON_CYC);
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
		d = rdata;
	endtask
	task automatic wait_state(input logic [2:0] s, input int n);
		for (int i = 0; i < n; i++) begin
			rd_reg(REG_STATUS, v);
			if (v[2:0] === s)
				break;
		end
		check({29'h0, v[2:0]}, {29'h0, s});
	endtask
	task automatic give_verdict;
		if (mismatches == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// ----
	// sequence
	// ----
	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			rd_reg(ra[i], v);
			check(v, rv[i]);
		end
		lfsr = next_rand(lfsr);
		duty = 32'h20 + {27'h0, lfsr[4:0]};
		wr_reg(REG_DUTY, duty);
		wr_reg(REG_PERIOD, 32'hB2);
		wr_reg(REG_STATUS, 32'hFFFFFFFF);
		wr_reg(8'h14, 32'hFFFFFFFF);
		rd_reg(REG_DUTY, v);
		check(v, duty);
		rd_reg(8'h14, v);
		check(v, 32'h0);
		wait_state(ST_OFF, 1);
		pre <= 1'b1;
		en <= 1'b1;
		wait_state(ST_HIZ, 10);
		check({30'h0, ugoe, lgoe}, 32'h0);
		en <= 1'b0;
		wait_state(ST_OFF, 10);
		pre <= 1'b0;
		repeat (10) @(posedge clk);
		en <= 1'b1;
		wait_state(ST_PRECHARGE, 3);
		wait_state(ST_SOFTSTART, 2500);
		check(32'(pc_pulses), 32'h40);
		check({31'h0, v[4]}, {31'h0, low_skip(v[18:9])});
		check({21'h0, v[29:19]}, 32'hB2);
		uv <= 1'b1;
		repeat (20 + lfsr[9:5]) @(posedge clk);
		uv <= 1'b0;
		wait_state(ST_SOFTSTART, 1);
		for (int i = 0; i < 20000 && ug !== 1'b1; i++)
			@(posedge clk);
		oc <= 1'b1;
		repeat (6) @(posedge clk);
		check({31'h0, ug}, 32'h0);
		oc <= 1'b0;
		rd_reg(REG_IRQ, v);
		check({31'h0, v[1]}, 32'h1);
		wr_reg(REG_IRQ, 32'h3F);
		for (int i = 0; i < 400 && ug !== 1'b1; i++)
			@(posedge clk);
		ov <= 1'b1;
		repeat (10) @(posedge clk);
		check({30'h0, ug, lg}, 32'h1);
		ov <= 1'b0;
		rd_reg(REG_IRQ, v);
		check(v, 32'h4);
		check({31'h0, irq}, 32'h0);
		wr_reg(REG_MASK, 32'h4);
		repeat (2) @(posedge clk);
		check({31'h0, irq}, 32'h1);
		wr_reg(REG_IRQ, 32'h4);
		repeat (2) @(posedge clk);
		check({31'h0, irq}, 32'h0);
		leak <= 1'b1;
		repeat (1500) @(posedge clk);
		leak <= 1'b0;
		rd_reg(REG_IRQ, v);
		check({31'h0, v[3]}, 32'h1);
		v = 32'h0;
		for (int i = 0; i < 9000 && v[3] !== 1'b1; i++)
			rd_reg(REG_STATUS, v);
		check({31'h0, v[3]}, 32'h1);
		uv <= 1'b1;
		wait_state(ST_RETRY, 5);
		uv <= 1'b0;
		rd_reg(REG_IRQ, v);
		check({31'h0, v[0]}, 32'h1);
		rmode <= 1'b0;
		repeat (1500) @(posedge clk);
		wait_state(ST_RETRY, 1);
		check({21'h0, v[29:19]}, 32'hFA);
		ext_half <= 39;
		repeat (1000) @(posedge clk);
		rd_reg(REG_IRQ, v);
		check({31'h0, v[5]}, 32'h1);
		en <= 1'b0;
		wait_state(ST_OFF, 5);
		check({22'h0, v[18:9]}, 32'h0);
		check({30'h0, ug, lg}, 32'h0);
		check({31'h0, shoot}, 32'h0);
		give_verdict;
	end
endmodule // buck_softstart_protection_seq_bench
`default_nettype wire
